// [verilog/wdg_regs.svh]
// register map, field positions, reset values and timing figures of the watchdog
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_ADDR_W          8
`define WDG_DATA_W          32

`define WDG_OFS_CONFIG      8'h00
`define WDG_OFS_STATUS      8'h04
`define WDG_OFS_MASK        8'h08
`define WDG_OFS_COUNT       8'h0c

`define WDG_CFG_ENABLE_BIT  0
`define WDG_CFG_PRESEL_BIT  1
`define WDG_CFG_POST_LSB    4
`define WDG_CFG_POST_MSB    7

`define WDG_ST_IDLE_BIT     2
`define WDG_ST_SLEEP_BIT    3
`define WDG_ST_TIMEOUT_BIT  4

`define WDG_RST_ENABLE      1'h1
`define WDG_RST_PRESEL      1'h1
`define WDG_RST_POST        4'hf
`define WDG_RST_MASK        3'h0

`define WDG_PRE_SHORT_END   7'h1f
`define WDG_PRE_LONG_END    7'h7f
`define WDG_POST_FULL       15'h7fff
`define WDG_POST_SEL_MAX    4'hf

`define WDG_LOW_POWER_RC_OSC_HZ         31000
`define WDG_PRE_SHORT_US    1000
`define WDG_PRE_LONG_US     4000

`endif

// [verilog/wdg_pkg.sv]
// types shared by the watchdog design files
package wdg_pkg;

  typedef enum logic [2:0]
  {
    WDG_RUN   = 3'h1,
    WDG_SLEEP = 3'h2,
    WDG_IDLE  = 3'h4
  } wdg_mode_t;

endpackage

// [verilog/wdg_sync3.sv]
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
module wdg_sync3
  import wdg_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic asyncIn,
  output logic      level,
  output logic      rise
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;
  logic       next_rise;

  always_comb
  begin
    next_stage = {stage[1:0], asyncIn};
    next_level = level;
    next_rise  = 1'h0;
    // first stage only feeds the second; agreement of second and third commits
    if (stage[1] == stage[2])
    begin
      next_level = stage[2];
      next_rise  = stage[2] & ~level;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stage <= 3'h0;
      level <= 1'h0;
      rise  <= 1'h0;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
      rise  <= next_rise;
    end
  end

endmodule

// [verilog/wdg_timer.sv]
// watchdog core: oscillator edge counting, prescaler, postscaler, power modes, registers
`timescale 1ns/10ps
`include "wdg_regs.svh"
module wdg_timer
  import wdg_pkg::*;
#(
  parameter int PRE_W  = 7,
  parameter int POST_W = 15
)
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [`WDG_ADDR_W-1:0]  regAddr,
  input  wire logic [`WDG_DATA_W-1:0]  regWrData,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [`WDG_DATA_W-1:0]  regRdData,
  input  wire logic                    lowPowerRcOsc,
  output logic                         lowPowerRcOscEnable,
  input  wire logic                    clearWatchdogInstr,
  input  wire logic                    powerSaveInstr,
  input  wire logic                    powerSaveIdle,
  input  wire logic                    oscSwitchDone,
  input  wire logic                    wakeRequest,
  output logic                         deviceResetReq,
  output logic                         wakeCore,
  output logic                         sleepActive,
  output logic                         idleActive,
  output logic                         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // oscillator input

  logic oscLevel;
  logic oscRise;

  wdg_sync3 u_oscSync
  (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (lowPowerRcOsc),
    .level   (oscLevel),
    .rise    (oscRise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration and mask registers

  logic       cfgEnable;
  logic       cfgPresel;
  logic [3:0] cfgPost;
  logic [2:0] intMask;
  logic       next_cfgEnable;
  logic       next_cfgPresel;
  logic [3:0] next_cfgPost;
  logic [2:0] next_intMask;
  logic       wrConfig;
  logic       wrStatus;
  logic       wrMask;

  always_comb
  begin
    wrConfig       = regWrite && (regAddr == `WDG_OFS_CONFIG);
    wrStatus       = regWrite && (regAddr == `WDG_OFS_STATUS);
    wrMask         = regWrite && (regAddr == `WDG_OFS_MASK);
    next_cfgEnable = cfgEnable;
    next_cfgPresel = cfgPresel;
    next_cfgPost   = cfgPost;
    next_intMask   = intMask;
    if (wrConfig)
    begin
      next_cfgEnable = regWrData[`WDG_CFG_ENABLE_BIT];
      next_cfgPresel = regWrData[`WDG_CFG_PRESEL_BIT];
      next_cfgPost   = regWrData[`WDG_CFG_POST_MSB:`WDG_CFG_POST_LSB];
    end
    if (wrMask)
    begin
      next_intMask = regWrData[`WDG_ST_TIMEOUT_BIT:`WDG_ST_IDLE_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cfgEnable <= `WDG_RST_ENABLE;
      cfgPresel <= `WDG_RST_PRESEL;
      cfgPost   <= `WDG_RST_POST;
      intMask   <= `WDG_RST_MASK;
    end
    else
    begin
      cfgEnable <= next_cfgEnable;
      cfgPresel <= next_cfgPresel;
      cfgPost   <= next_cfgPost;
      intMask   <= next_intMask;
    end
  end

  // the oscillator runs exactly while the watchdog is enabled
  assign lowPowerRcOscEnable = cfgEnable;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, postscaler and power mode

  wdg_mode_t          mode;
  wdg_mode_t          next_mode;
  logic [PRE_W-1:0]   preCount;
  logic [PRE_W-1:0]   next_preCount;
  logic [POST_W-1:0]  postCount;
  logic [POST_W-1:0]  next_postCount;
  logic [PRE_W-1:0]   preEnd;
  logic [POST_W-1:0]  postEnd;
  logic               tick;
  logic               timeout;
  logic               enterLowPower;
  logic               exitLowPower;
  logic               clearCounters;
  logic               next_deviceResetReq;
  logic               next_wakeCore;

  always_comb
  begin
    // oscillator edges are counted in every mode while enabled
    tick          = oscRise && cfgEnable;
    preEnd        = cfgPresel ? `WDG_PRE_LONG_END : `WDG_PRE_SHORT_END;
    // ratio is two to the power of the field: 0 gives 1:1, 15 gives 1:32768
    postEnd       = `WDG_POST_FULL >> (`WDG_POST_SEL_MAX - cfgPost);
    timeout       = tick && (preCount == preEnd) && (postCount == postEnd);
    enterLowPower = powerSaveInstr && (mode == WDG_RUN);
    exitLowPower  = (mode != WDG_RUN) && (wakeRequest || timeout);
    clearCounters = 1'h0;
    if (clearWatchdogInstr && (mode == WDG_RUN))
    begin
      clearCounters = 1'h1;
    end
    if (oscSwitchDone)
    begin
      clearCounters = 1'h1;
    end
    if (enterLowPower)
    begin
      clearCounters = 1'h1;
    end
    if (exitLowPower)
    begin
      clearCounters = 1'h1;
    end
    // a disabled watchdog restarts from zero when enabled again
    if (timeout || !cfgEnable)
    begin
      clearCounters = 1'h1;
    end

    next_preCount  = preCount;
    next_postCount = postCount;
    if (clearCounters)
    begin
      next_preCount  = '0;
      next_postCount = '0;
    end
    else if (tick)
    begin
      if (preCount == preEnd)
      begin
        next_preCount  = '0;
        next_postCount = postCount + POST_W'(1);
      end
      else
      begin
        next_preCount = preCount + PRE_W'(1);
      end
    end

    next_mode = mode;
    unique case (mode)
      WDG_RUN:
      begin
        if (enterLowPower)
        begin
          next_mode = powerSaveIdle ? WDG_IDLE : WDG_SLEEP;
        end
      end
      WDG_SLEEP, WDG_IDLE:
      begin
        if (exitLowPower)
        begin
          next_mode = WDG_RUN;
        end
      end
      default:
      begin
        next_mode = WDG_RUN;
      end
    endcase

    // outside low power a time-out resets the device
    next_deviceResetReq = timeout && (mode == WDG_RUN);
    next_wakeCore       = exitLowPower;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      // any device reset lands here
      mode           <= WDG_RUN;
      preCount       <= '0;
      postCount      <= '0;
      deviceResetReq <= 1'h0;
      wakeCore       <= 1'h0;
    end
    else
    begin
      mode           <= next_mode;
      preCount       <= next_preCount;
      postCount      <= next_postCount;
      deviceResetReq <= next_deviceResetReq;
      wakeCore       <= next_wakeCore;
    end
  end

  assign sleepActive = mode[1];
  assign idleActive  = mode[2];

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, interrupt and read port

  logic                    stTimeout;
  logic                    stSleep;
  logic                    stIdle;
  logic                    next_stTimeout;
  logic                    next_stSleep;
  logic                    next_stIdle;
  logic                    next_irq;
  logic [`WDG_DATA_W-1:0]  next_regRdData;
  logic [`WDG_DATA_W-1:0]  statusWord;

  always_comb
  begin
    // write one clears; a same-cycle event wins over the clear
    next_stTimeout = stTimeout && !(wrStatus && regWrData[`WDG_ST_TIMEOUT_BIT]);
    next_stSleep   = stSleep && !(wrStatus && regWrData[`WDG_ST_SLEEP_BIT]);
    next_stIdle    = stIdle && !(wrStatus && regWrData[`WDG_ST_IDLE_BIT]);
    if (timeout)
    begin
      next_stTimeout = 1'h1;
    end
    if (enterLowPower && !powerSaveIdle)
    begin
      next_stSleep = 1'h1;
    end
    if (enterLowPower && powerSaveIdle)
    begin
      next_stIdle = 1'h1;
    end
    next_irq = |({next_stTimeout, next_stSleep, next_stIdle} & next_intMask);

    statusWord = '0;
    statusWord[`WDG_ST_TIMEOUT_BIT] = stTimeout;
    statusWord[`WDG_ST_SLEEP_BIT]   = stSleep;
    statusWord[`WDG_ST_IDLE_BIT]    = stIdle;

    next_regRdData = '0;
    if (regRead)
    begin
      unique case (regAddr)
        `WDG_OFS_CONFIG:
        begin
          next_regRdData[`WDG_CFG_ENABLE_BIT]                   = cfgEnable;
          next_regRdData[`WDG_CFG_PRESEL_BIT]                   = cfgPresel;
          next_regRdData[`WDG_CFG_POST_MSB:`WDG_CFG_POST_LSB]   = cfgPost;
        end
        `WDG_OFS_STATUS:
        begin
          next_regRdData = statusWord;
        end
        `WDG_OFS_MASK:
        begin
          next_regRdData[`WDG_ST_TIMEOUT_BIT:`WDG_ST_IDLE_BIT] = intMask;
        end
        `WDG_OFS_COUNT:
        begin
          next_regRdData[POST_W-1:0] = postCount;
        end
        default:
        begin
          next_regRdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stTimeout <= 1'h0;
      stSleep   <= 1'h0;
      stIdle    <= 1'h0;
      irq       <= 1'h0;
      regRdData <= '0;
    end
    else
    begin
      stTimeout <= next_stTimeout;
      stSleep   <= next_stSleep;
      stIdle    <= next_stIdle;
      irq       <= next_irq;
      regRdData <= next_regRdData;
    end
  end

endmodule

// [sim/wdg_timer_chk.sv]
// port-level assertions of the watchdog timer
`timescale 1ns/10ps
`include "wdg_regs.svh"
module wdg_timer_chk
(
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic [`WDG_ADDR_W-1:0] regAddr,
  input wire logic [`WDG_DATA_W-1:0] regWrData,
  input wire logic                   regWrite,
  input wire logic                   powerSaveInstr,
  input wire logic                   powerSaveIdle,
  input wire logic                   wakeRequest,
  input wire logic                   lowPowerRcOscEnable,
  input wire logic                   deviceResetReq,
  input wire logic                   wakeCore,
  input wire logic                   sleepActive,
  input wire logic                   idleActive,
  input wire logic                   irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  sequence s_low;
    sleepActive || idleActive;
  endsequence
  sequence s_enter;
    powerSaveInstr && !sleepActive && !idleActive;
  endsequence
  // reset itself must not mask this one
  property p_rst;
    disable iff (1'h0) !resetn |=> !sleepActive && !idleActive && !wakeCore && !deviceResetReq && !irq
      && lowPowerRcOscEnable;
  endproperty
  property p_en;
    regWrite && regAddr == `WDG_OFS_CONFIG |=> lowPowerRcOscEnable == $past(regWrData[0]);
  endproperty
  property p_enter;
    s_enter |=> sleepActive == !$past(powerSaveIdle) && idleActive == $past(powerSaveIdle);
  endproperty
  property p_excl;
    !(sleepActive && idleActive);
  endproperty
  property p_stay;
    s_low |=> sleepActive || idleActive || wakeCore;
  endproperty
  property p_wreq;
    s_low ##0 wakeRequest |=> wakeCore && !sleepActive && !idleActive;
  endproperty
  property p_wrun;
    wakeCore |-> !sleepActive && !idleActive && $past(sleepActive || idleActive);
  endproperty
  property p_wpulse;
    wakeCore |=> !wakeCore;
  endproperty
  property p_dres;
    deviceResetReq |-> !$past(sleepActive || idleActive) ##1 !deviceResetReq;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  a_en: assert property (p_en)
    else $error("oscillator enable does not follow config");
  a_enter: assert property (p_enter)
    else $error("wrong low power mode entered");
  a_excl: assert property (p_excl)
    else $error("sleep and idle both active");
  a_stay: assert property (p_stay)
    else $error("low power left without wake");
  a_wreq: assert property (p_wreq)
    else $error("wake request not honoured");
  a_wrun: assert property (p_wrun)
    else $error("wake pulse without low power exit");
  a_wpulse: assert property (p_wpulse)
    else $error("wake pulse too long");
  a_dres: assert property (p_dres)
    else $error("bad device reset request");
endmodule
bind wdg_timer wdg_timer_chk u_chk
(
  .clk                 (clk),
  .resetn              (resetn),
  .regAddr             (regAddr),
  .regWrData           (regWrData),
  .regWrite            (regWrite),
  .powerSaveInstr      (powerSaveInstr),
  .powerSaveIdle       (powerSaveIdle),
  .wakeRequest         (wakeRequest),
  .lowPowerRcOscEnable (lowPowerRcOscEnable),
  .deviceResetReq      (deviceResetReq),
  .wakeCore            (wakeCore),
  .sleepActive         (sleepActive),
  .idleActive          (idleActive),
  .irq                 (irq)
);

// [sim/wdg_timer_tb_top.sv]
// self-checking bench of the watchdog timer
`timescale 1ns/10ps
`include "wdg_regs.svh"
module wdg_timer_tb_top;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] regRdData;
  logic        regWrite = 1'h0, regRead = 1'h0, lowPowerRcOsc = 1'h0, clearWatchdogInstr = 1'h0;
  logic        powerSaveInstr = 1'h0, powerSaveIdle = 1'h0, oscSwitchDone = 1'h0, wakeRequest = 1'h0;
  logic        lowPowerRcOscEnable, deviceResetReq, wakeCore, sleepActive, idleActive, irq;
  int          miscompares = 0, nTests = 0, nReset = 0, nWake = 0;

  wdg_timer dut
  (
    .clk                 (clk),
    .resetn              (resetn),
    .regAddr             (regAddr),
    .regWrData           (regWrData),
    .regWrite            (regWrite),
    .regRead             (regRead),
    .regRdData           (regRdData),
    .lowPowerRcOsc       (lowPowerRcOsc),
    .lowPowerRcOscEnable (lowPowerRcOscEnable),
    .clearWatchdogInstr  (clearWatchdogInstr),
    .powerSaveInstr      (powerSaveInstr),
    .powerSaveIdle       (powerSaveIdle),
    .oscSwitchDone       (oscSwitchDone),
    .wakeRequest         (wakeRequest),
    .deviceResetReq      (deviceResetReq),
    .wakeCore            (wakeCore),
    .sleepActive         (sleepActive),
    .idleActive          (idleActive),
    .irq                 (irq)
  );
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    nReset <= nReset + int'(deviceResetReq === 1'h1);
    nWake <= nWake + int'(wakeCore === 1'h1);
  end
  ////////////////////////////////////////
  task check(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clk) regWrite <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk) regRead <= 1'h0;
    #1 check(regRdData, e);
  endtask
  // slow edges so the synchroniser always sees both levels
  task edges(input int n);
    repeat (n)
    begin
      @(posedge clk) lowPowerRcOsc <= 1'h1;
      repeat (8) @(posedge clk);
      lowPowerRcOsc <= 1'h0;
      repeat (8) @(posedge clk);
    end
  endtask
  task expire(input logic [31:0] cfg, input int n);
    int r;
    wr(`WDG_OFS_CONFIG, cfg);
    r = nReset;
    edges(n - 1);
    check(nReset, r);
    edges(1);
    check(nReset, r + 1);
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset();
    check(lowPowerRcOscEnable, 1);
    rd(`WDG_OFS_CONFIG, 32'hf3);
    rd(`WDG_OFS_STATUS, 32'h0);
    rd(`WDG_OFS_COUNT, 32'h0);
    rd(8'h10, 32'h0);
  endtask
  task t_timeout();
    expire(32'h01, 32);
    expire(32'h11, 64);
    expire(32'h03, 128);
    rd(`WDG_OFS_STATUS, 32'h10);
    wr(`WDG_OFS_MASK, 32'h10);
    #1 check(irq, 1);
    wr(`WDG_OFS_STATUS, 32'h10);
    #1 check(irq, 0);
    rd(`WDG_OFS_STATUS, 32'h0);
  endtask
  task t_clear();
    int r;
    wr(`WDG_OFS_CONFIG, 32'h01);
    for (int k = 0; k < 2; k++)
    begin
      edges(20);
      @(posedge clk) clearWatchdogInstr <= (k == 0);
      oscSwitchDone <= (k == 1);
      @(posedge clk) clearWatchdogInstr <= 1'h0;
      oscSwitchDone <= 1'h0;
      r = nReset;
      edges(31);
      check(nReset, r);
      edges(1);
      check(nReset, r + 1);
    end
  endtask
  // 20 edges before entry plus 31 after would expire unless entry clears
  task t_sleep();
    int r;
    int w;
    for (int k = 0; k < 2; k++)
    begin
      edges(20);
      @(posedge clk) powerSaveInstr <= 1'h1;
      powerSaveIdle <= (k == 1);
      @(posedge clk) powerSaveInstr <= 1'h0;
      #1 check({sleepActive, idleActive}, (k == 1) ? 2'h1 : 2'h2);
      w = nWake;
      r = nReset;
      edges(31);
      check(nWake, w);
      if (k == 0)
      begin
        edges(1);
        check(nWake, w + 1);
        check(nReset, r);
        rd(`WDG_OFS_STATUS, 32'h18);
      end
      else
      begin
        @(posedge clk) wakeRequest <= 1'h1;
        @(posedge clk) wakeRequest <= 1'h0;
        repeat (2) @(posedge clk);
        check(nWake, w + 1);
        edges(31);
        check(nReset, r);
        edges(1);
        check(nReset, r + 1);
        rd(`WDG_OFS_STATUS, 32'h14);
      end
      wr(`WDG_OFS_STATUS, 32'h1c);
      rd(`WDG_OFS_STATUS, 32'h0);
    end
  endtask
  task t_disable();
    int r;
    wr(`WDG_OFS_CONFIG, 32'h00);
    #1 check(lowPowerRcOscEnable, 0);
    r = nReset;
    edges(40);
    check(nReset, r);
    wr(`WDG_OFS_CONFIG, 32'h01);
    #1 check(lowPowerRcOscEnable, 1);
  endtask
  // reset in mid-count: a left-over prescaler count would expire early
  task t_midreset();
    wr(`WDG_OFS_CONFIG, 32'hf1);
    edges(70);
    rd(`WDG_OFS_COUNT, 32'h2);
    @(posedge clk) resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    rd(`WDG_OFS_CONFIG, 32'hf3);
    rd(`WDG_OFS_COUNT, 32'h0);
    expire(32'h01, 32);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    #1 t_reset();
    t_timeout();
    t_clear();
    t_sleep();
    t_disable();
    t_midreset();
    give_verdict();
  end
endmodule
